// ---- picb_pkg.sv ----
// Package: register map, field layout and reset values of the posted interrupt bank
package picb_pkg;
	// ==========================================
	// Register byte offsets
	localparam logic [7:0] CLR_ANALOG_SUPPLY_OFS = 8'hDA;
	localparam logic [7:0] CLR_DIGITAL_ROWS01_OFS = 8'hDB;
	localparam logic [7:0] CLR_DIGITAL_ROW2_OFS = 8'hDC;
	localparam logic [7:0] CLR_MISC_SOURCES_OFS = 8'hDD;
	localparam logic [7:0] MASK_MISC_SOFT_OFS = 8'hDE;
	localparam logic [7:0] IRQ_STATUS_OFS = 8'hE8;
	localparam logic [7:0] IRQ_MASK_OFS = 8'hEC;
	// ==========================================
	// Field layout
	localparam int SOFT_EN_BIT = 7;
	localparam logic [7:0] ANALOG_SUPPLY_VALID = 8'h0F;
	localparam logic [7:0] ROWS01_VALID = 8'hFF;
	localparam logic [7:0] ROW2_VALID = 8'h0F;
	localparam logic [7:0] MISC_VALID = 8'h3F;
	localparam logic [7:0] MASK3_VALID = 8'hBF;
	localparam logic [3:0] EVT_VALID = 4'hF;
	// ==========================================
	// Reset values
	localparam logic [7:0] POSTED_RST = 8'h00;
	localparam logic [7:0] MASK_RST = 8'h00;
	localparam logic [3:0] EVT_RST = 4'h0;
	localparam logic [31:0] UNMAPPED_READ = 32'h00000000;
endpackage

// ---- posted_irq_bank.sv ----
// Posted interrupt flags, clear/force registers and misc mask with Wishbone access
// Overview of operation
// - A read of a clear register returns 1 for each source that has a posted flag, else 0.
// - Writing 0 to a clear bit with the soft enable low clears that posted flag.
// - Writing 1 with soft enable low, or 0 with it high, leaves the flag alone.
// - Writing 1 with soft enable high posts that source as though it had fired.
// - Bit 7 of the misc mask register is the soft enable: 0 selects clears, 1 software posting.
// - A misc mask bit of 0 keeps its posted source from becoming pending.
// - A misc mask bit of 1 lets its posted source become pending.
// - Masking never stops posting; it only gates posted to pending.
// - Misc mask bits 5..0 each gate their own source, and bit 6 is reserved.
// - Clear register 0 bits 3..1 are analog columns 2..0 and bit 0 the supply monitor.
// - Clear register 1 maps row 1 blocks 3,2,1,0 to bits 7..4 and row 0 to bits 3..0.
// - Clear register 2 bits 3..0 are row 2 blocks 3..0 and bits 7..4 are reserved.
// - Clear and mask register 3 share order: analog 5,4, clock, converter, serial 1,0.
`timescale 1ns/1ns
`default_nettype none
module picb_posted_irq_bank (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic wbCyc,
	input wire logic wbStb,
	input wire logic wbWe,
	input wire logic [7:0] wbAdr,
	input wire logic [3:0] wbSel,
	input wire logic [31:0] wbDatI,
	output logic [31:0] wbDatO,
	output logic wbAck,
	input wire logic [3:0] analogSupplySrc,
	input wire logic [7:0] digitalRows01Src,
	input wire logic [3:0] digitalRow2Src,
	input wire logic [5:0] miscSrc,
	output logic [5:0] miscPending,
	output logic softIrqEnable,
	output logic irq
);
	// ==========================================
	// Bus decode
	logic ackR;
	logic reqValid;
	logic wrStrobe;
	logic lane0;
	assign reqValid = wbCyc & wbStb & ~ackR;
	assign wrStrobe = reqValid & wbWe & lane0;
	assign lane0 = wbSel[0];
	logic [6:0] selHit;
	assign selHit[0] = wbAdr == picb_pkg::CLR_ANALOG_SUPPLY_OFS;
	assign selHit[1] = wbAdr == picb_pkg::CLR_DIGITAL_ROWS01_OFS;
	assign selHit[2] = wbAdr == picb_pkg::CLR_DIGITAL_ROW2_OFS;
	assign selHit[3] = wbAdr == picb_pkg::CLR_MISC_SOURCES_OFS;
	assign selHit[4] = wbAdr == picb_pkg::MASK_MISC_SOFT_OFS;
	assign selHit[5] = wbAdr == picb_pkg::IRQ_STATUS_OFS;
	assign selHit[6] = wbAdr == picb_pkg::IRQ_MASK_OFS;
	// ==========================================
	// Posted flag banks, one generate instance per clear register
	logic [7:0] postedR [4];
	logic [7:0] srcVec [4];
	logic [7:0] validVec [4];
	logic [7:0] mask3_r;
	assign srcVec[0] = {4'h0, analogSupplySrc};
	assign srcVec[1] = digitalRows01Src;
	assign srcVec[2] = {4'h0, digitalRow2Src};
	assign srcVec[3] = {2'h0, miscSrc};
	assign validVec[0] = picb_pkg::ANALOG_SUPPLY_VALID;
	assign validVec[1] = picb_pkg::ROWS01_VALID;
	assign validVec[2] = picb_pkg::ROW2_VALID;
	assign validVec[3] = picb_pkg::MISC_VALID;
	assign softIrqEnable = mask3_r[picb_pkg::SOFT_EN_BIT];
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : gBank
			logic [7:0] wrData;
			logic [7:0] clrBits;
			logic [7:0] setBits;
			logic [7:0] posted_nxt;
			logic hit;
			assign hit = wrStrobe & selHit[g];
			assign wrData = wbDatI[7:0] & validVec[g];
			// Zero writes clear only while soft enable is low
			assign clrBits = (hit & ~softIrqEnable) ? (~wbDatI[7:0] & validVec[g]) : 8'h00;
			// One writes post only while soft enable is high
			assign setBits = (hit & softIrqEnable) ? wrData : 8'h00;
			// Set wins over clear so a coincident event survives
			assign posted_nxt = ((postedR[g] & ~clrBits) | setBits | srcVec[g]) & validVec[g];
			always_ff @(posedge ref_clk) begin
				if (srst) begin
					postedR[g] <= picb_pkg::POSTED_RST;
				end else begin
					postedR[g] <= posted_nxt;
				end
			end
		end
	endgenerate
	// ==========================================
	// Misc mask and pending gate
	logic [7:0] mask3_nxt;
	// Reserved bit 6 never stores, so it reads zero whatever software writes
	assign mask3_nxt = (wrStrobe & selHit[4]) ? (wbDatI[7:0] & picb_pkg::MASK3_VALID) : mask3_r;
	// Pending needs both the posted flag and an unmask bit
	assign miscPending = postedR[3][5:0] & mask3_r[5:0];
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			mask3_r <= picb_pkg::MASK_RST;
		end else begin
			mask3_r <= mask3_nxt;
		end
	end
	// ==========================================
	// Interrupt status: bit n sets when bank n has any posted flag
	logic [3:0] evtStat_r;
	logic [3:0] evtMask_r;
	logic [3:0] evtRaise;
	logic [3:0] evtStat_nxt;
	logic [3:0] evtMask_nxt;
	generate
		for (g = 0; g < 4; g++) begin : gEvt
			assign evtRaise[g] = |postedR[g];
		end
	endgenerate
	// Write one to clear, but a raise in the same cycle wins
	assign evtStat_nxt = (wrStrobe & selHit[5]) ? ((evtStat_r & ~wbDatI[3:0]) | evtRaise) :
		(evtStat_r | evtRaise);
	assign evtMask_nxt = (wrStrobe & selHit[6]) ? (wbDatI[3:0] & picb_pkg::EVT_VALID) : evtMask_r;
	assign irq = |(evtStat_r & evtMask_r);
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			evtStat_r <= picb_pkg::EVT_RST;
			evtMask_r <= picb_pkg::EVT_RST;
		end else begin
			evtStat_r <= evtStat_nxt;
			evtMask_r <= evtMask_nxt;
		end
	end
	// ==========================================
	// Read mux and ack; registered ack and data one cycle after the request, unmapped reads return zero
	logic [31:0] rdMux;
	assign rdMux = selHit[0] ? {24'h000000, postedR[0]} :
		selHit[1] ? {24'h000000, postedR[1]} :
		selHit[2] ? {24'h000000, postedR[2]} :
		selHit[3] ? {24'h000000, postedR[3]} :
		selHit[4] ? {24'h000000, mask3_r} :
		selHit[5] ? {28'h0000000, evtStat_r} :
		selHit[6] ? {28'h0000000, evtMask_r} : picb_pkg::UNMAPPED_READ;
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ackR <= 1'b0;
			wbDatO <= picb_pkg::UNMAPPED_READ;
		end else begin
			ackR <= reqValid;
			wbDatO <= reqValid ? rdMux : wbDatO;
		end
	end
	assign wbAck = ackR;
endmodule
`default_nettype wire

// ---- picb_monitor.sv ----
// Port assertions for the posted interrupt bank
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Checker
module picb_monitor (
	input wire logic ref_clk, srst, wbCyc, wbStb, wbWe, wbAck, softIrqEnable, irq,
	input wire logic [7:0] wbAdr,
	input wire logic [3:0] wbSel,
	input wire logic [31:0] wbDatI, wbDatO,
	input wire logic [5:0] miscSrc, miscPending
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	wire tk = wbCyc && wbStb && !wbAck;
	wire wr = tk && wbWe && wbSel[0];
	wire wrC = wr && wbAdr == 8'hDD;
	wire wrM = wr && wbAdr == 8'hDE;
	ack_pulse_a: assert property (wbAck |=> !wbAck) else $error("ack too long");
	ack_lat_a: assert property (tk |=> wbAck) else $error("ack missing");
	rd_high_a: assert property (tk && !wbWe |=> wbDatO[31:8] == 24'h0) else $error("high bits");
	soft_load_a: assert property (wrM |=> softIrqEnable == $past(wbDatI[7]))
		else $error("soft enable not loaded");
	clr_zero_a: assert property (wrC && !softIrqEnable && !wbDatI[0] && !miscSrc[0]
		|=> !miscPending[0]) else $error("flag not cleared");
	keep_one_a: assert property (wrC && softIrqEnable != wbDatI[0] && !miscSrc[0]
		|=> $stable(miscPending[0])) else $error("flag changed");
	src_keep_a: assert property (miscSrc[0] && miscPending[0] && !wrM |=> miscPending[0])
		else $error("event lost");
	pend_cause_a: assert property ($rose(miscPending[0])
		|-> $past(miscSrc[0] || wrM || wrC && softIrqEnable)) else $error("pending uncaused");
	cover property (wrC && softIrqEnable);
	cover property (irq);
	cover property (wrC && miscSrc[0]);
endmodule
bind picb_posted_irq_bank picb_monitor i_mon (.ref_clk, .srst, .wbCyc, .wbStb, .wbWe,
	.wbAck, .softIrqEnable, .irq, .wbAdr, .wbSel, .wbDatI, .wbDatO, .miscSrc, .miscPending);
`default_nettype wire

// ---- test_posted_interrupt_clear_mask_bank.sv ----
// Self-checking bench for the posted interrupt bank
`timescale 1ns/1ns
`default_nettype none
module test_posted_interrupt_clear_mask_bank;
	logic ref_clk = 0, srst = 1, wbCyc = 0, wbStb = 0, wbWe = 0, wbAck, softIrqEnable, irq;
	logic [7:0] wbAdr = 8'h00, r01 = 8'h00;
	logic [3:0] wbSel = 4'h0, aSrc = 4'h0, r2 = 4'h0;
	logic [31:0] wbDatI = 32'h0, wbDatO, q;
	logic [5:0] miscSrc = 6'h00, miscPending;
	int miscompares = 0, samples_checked = 0, cycles = 0;
	always #5 ref_clk = ~ref_clk;
	picb_posted_irq_bank i_dut (.ref_clk, .srst, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel,
		.wbDatI, .wbDatO, .wbAck, .analogSupplySrc(aSrc), .digitalRows01Src(r01),
		.digitalRow2Src(r2), .miscSrc, .miscPending, .softIrqEnable, .irq);
	// ==========================================
	// Shared tasks
	task summarize;
		$display("checked %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			miscompares++;
			summarize;
		end
	end
	task chk(input logic [31:0] e, g);
		samples_checked++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected at %0t exp %h got %h", $time, e, g);
		end
	endtask
	// Request held until ack is sampled, so no fixed latency is assumed
	task bus(input logic w, input logic [7:0] a, d);
		@(posedge ref_clk);
		{wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatI} <= {2'b11, w, a, 4'h1, 24'h0, d};
		do @(posedge ref_clk); while (wbAck !== 1'b1);
		q = wbDatO;
		{wbCyc, wbStb} <= 2'b00;
	endtask
	task rd(input logic [7:0] a, e);
		bus(0, a, 8'h00);
		chk({24'h0, e}, q);
	endtask
	// ==========================================
	// Scenarios
	task t_map;
		rd(8'hDA, 8'h00);
		rd(8'hDE, 8'h00);
		rd(8'h00, 8'h00);
		@(posedge ref_clk);
		{aSrc, r01, r2, miscSrc} <= {4'hA, 8'hA5, 4'h6, 6'h29};
		@(posedge ref_clk);
		{aSrc, r01, r2, miscSrc} <= 22'h0;
		rd(8'hDA, 8'h0A);
		rd(8'hDC, 8'h06);
		rd(8'hDD, 8'h29);
		bus(1, 8'hDB, 8'h0F);
		rd(8'hDB, 8'h05);
		bus(1, 8'hDD, 8'h00);
		$display("map and clear done");
	endtask
	task t_soft;
		bus(1, 8'hDE, 8'h81);
		chk(32'h1, {31'h0, softIrqEnable});
		bus(1, 8'hDD, 8'h3F);
		rd(8'hDD, 8'h3F);
		chk(32'h1, {26'h0, miscPending});
		bus(1, 8'hDD, 8'h00);
		rd(8'hDD, 8'h3F);
		bus(1, 8'hDE, 8'h01);
		rd(8'hDE, 8'h01);
		bus(1, 8'hDD, 8'h00);
		chk(32'h0, {26'h0, miscPending});
		$display("soft posting done");
	endtask
	task t_race;
		miscSrc <= 6'h01;
		bus(1, 8'hDD, 8'h00);
		miscSrc <= 6'h00;
		rd(8'hDD, 8'h01);
		bus(1, 8'hEC, 8'h08);
		chk(32'h1, {31'h0, irq});
		bus(1, 8'hE8, 8'h08);
		chk(32'h1, {31'h0, irq});
		bus(1, 8'hDD, 8'h00);
		bus(1, 8'hE8, 8'h08);
		chk(32'h0, {31'h0, irq});
		bus(1, 8'hEC, 8'h00);
		chk(32'h0, {31'h0, irq});
		$display("race and irq done");
	endtask
	initial begin
		repeat (5) @(posedge ref_clk);
		srst <= 0;
		t_map;
		t_soft;
		t_race;
		summarize;
	end
endmodule
`default_nettype wire
